// ---- logic/sei_pkg.sv ----
package sei_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS    = 5;
   // wake-up settle time, figure chosen as a plain default
   localparam int unsigned RELEASE_DELAY_NS = 1000;
   // longest-time style count: round down, at least one cycle
   localparam int unsigned RELEASE_CYCLES_RAW = RELEASE_DELAY_NS / CLK_PERIOD_NS;
   localparam int unsigned RELEASE_CYCLES     = (RELEASE_CYCLES_RAW < 1) ? 1 : RELEASE_CYCLES_RAW;
   localparam int unsigned RELEASE_CNT_W      = $clog2(RELEASE_CYCLES + 1);

   // ----------------------------------------------------------------
   // frame layout
   // ----------------------------------------------------------------
   localparam logic [4:0] OPCODE_BITS = 5'h08;
   localparam logic [4:0] ADDR_BITS   = 5'h10;
   localparam logic [2:0] SIG_MSB     = 3'h7;
   localparam logic [4:0] BIT_CNT_RST = 5'h00;
   localparam logic [7:0] SHIFT_RST   = 8'h00;

   // ----------------------------------------------------------------
   // states of the serial sequencer
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SEI_IDLE,
      SEI_OPCODE,
      SEI_ADDR,
      SEI_SIG,
      SEI_DATA,
      SEI_IGNORE
   } sei_phase_e;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic csN;
      logic sck;
      logic si;
      logic holdN;
      logic wpN;
   } sei_pins_s;

   typedef struct packed {
      logic [7:0] rxByte;
      logic       rxStrobe;
      logic       rxFirst;
      logic       frameEnd;
      logic       writeStart;
   } sei_core_s;

endpackage

// ---- logic/sei_bus_interface.sv ----
`timescale 1ns/100ps
// Operation
// - in deep power-down every instruction but the wake/signature command is ignored
// - wake/signature also works awake, unless erase, program or status write busy
// - chip select low, wake opcode, 16 dummy address bits, then 8 signature bits
// - chip select high after the signature ends the frame, back to standby
// - further clocks keep repeating the signature until chip select rises
// - chip select high after only the opcode still wakes, standby after release delay
// - chip select low selects; high deselects, standby waits for a running program cycle
// - serial output is high impedance while deselected
// - chip select rising after a valid write sequence starts the self-timed write
// - serial input is sampled on each rising serial clock edge
// - serial output changes after each falling serial clock edge
// - protect pin low with enable bit set blocks nonvolatile status writes only
// - protect pin falling after a write cycle has begun does not affect it
// - protect enable clear makes the protect pin irrelevant
// - pause low while selected freezes the sequence, clock and input ignored
// - pause falling while clock high takes effect at next falling clock edge
// - pause rising while clock high resumes only at next falling clock edge
// - serial output floats at once when pause falls, drives at once when it rises
module sei_bus_interface #(
   parameter logic [7:0] WAKE_OPCODE = 8'h3c,  // wake/signature opcode, plain default
   parameter logic [7:0] SIGNATURE   = 8'h5a   // arbitrary value
) (
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_n,

   // raw pins and core status
   input  wire sei_pkg::sei_pins_s pinsIn,
   input  wire logic              enterPowerDown,
   input  wire logic              coreBusy,
   input  wire logic              writeArmed,
   input  wire logic              protectPinEnable,

   // serial output pin
   output logic                   soOut,
   output logic                   soEnN,

   // core-facing results
   output sei_pkg::sei_core_s     coreOut,
   output logic                   statusWriteBlocked,
   output logic                   deepPowerDown,
   output logic                   releasing,
   output logic                   standby
);

   // ----------------------------------------------------------------
   // timing limits
   // ----------------------------------------------------------------
   // every pin reaches the logic two clk_sys cycles late, through two flops
   // sck high and low must each last longer than one clk_sys cycle, or edges are lost
   // all pins share that latency, so their order on the wires is kept
   // serial input is taken on the synced rising clock, never on a falling one
   // the serial output moves one clk_sys cycle after the synced falling clock
   // a chip select already low at reset is taken as a selection once through the flops
   // a false deselect just after reset is harmless, the sequencer is idle
   // the release delay is counted in clk_sys cycles, not in serial clocks
   // a wake frame cut short by deselect after its full opcode still starts the release delay
   // a core still busy at deselect holds standby off until it finishes
   // the protect decision is frozen when the write cycle starts
   // a later protect pin change waits for the next write cycle
   // opcodes other than wake are swallowed in deep power-down until deselect
   // an awake wake opcode during a busy core is passed on as plain data
   // the signature repeats for as long as the host keeps clocking
   // pause freezes bit counter, shift register and signature index alike
   // while selected, pause is taken or dropped only while the synced clock is low
   // the output floats on pause after the pin latency, whatever the clock
   // a deselect during pause ends the frame and clears the pause
   // unknown phase codes fall back to idle instead of locking up

   // ----------------------------------------------------------------
   // state record
   // ----------------------------------------------------------------
   typedef struct packed {
      // pin sampling
      sei_pkg::sei_pins_s           syncA;       // first synchroniser stage
      sei_pkg::sei_pins_s           syncB;       // second synchroniser stage
      logic                         sckPrev;
      logic                         csPrev;

      // frame sequencing
      logic                         paused;
      sei_pkg::sei_phase_e          phase;
      logic [4:0]                   bitCnt;
      logic [7:0]                   shiftIn;
      logic [2:0]                   sigIdx;
      logic                         sigDone;
      logic                         wakeSeen;

      // serial output
      logic                         soBit;
      logic                         soDrive;

      // core results and power state
      sei_pkg::sei_core_s           core;
      logic                         blocked;
      logic                         dpd;
      logic                         rel;
      logic [sei_pkg::RELEASE_CNT_W-1:0] relCnt;
      logic                         pendStandby;
   } sei_state_s;

   sei_state_s st;
   sei_state_s next_st;

   // ----------------------------------------------------------------
   // decoded pin events
   // ----------------------------------------------------------------
   logic csN;
   logic sck;
   logic sckRise;
   logic sckFall;
   logic csRise;
   logic csFall;
   logic shiftOk;
   logic [7:0] shifted;
   logic wakeHit;
   logic writeGo;
   logic sigShift;
   logic protectNow;
   logic opcodeLast;
   logic addrLast;
   logic relLoad;
   logic relDone;

   // pin levels after the second flop only
   assign csN     = st.syncB.csN;
   assign sck     = st.syncB.sck;
   assign sckRise = sck & ~st.sckPrev;
   assign sckFall = ~sck & st.sckPrev;
   assign csRise  = csN & ~st.csPrev;
   assign csFall  = ~csN & st.csPrev;
   assign shiftOk = ~csN & ~st.paused & sckRise;
   assign shifted = {st.shiftIn[6:0], st.syncB.si};

   // ----------------------------------------------------------------
   // decoded frame events
   // ----------------------------------------------------------------
   // last bit of an opcode or data byte, last dummy address bit
   assign opcodeLast = (st.bitCnt == sei_pkg::OPCODE_BITS - 5'h01);
   assign addrLast   = (st.bitCnt == sei_pkg::ADDR_BITS - 5'h01);
   // wake opcode honoured asleep, or awake with the core idle
   assign wakeHit    = (shifted == WAKE_OPCODE) & (st.dpd | ~coreBusy);
   // deselect after a wake opcode while asleep starts the release delay
   assign relLoad    = csRise & st.wakeSeen & st.dpd;
   assign relDone    = st.rel & (st.relCnt == '0);
   // data frame closed by deselect with the core ready to write
   assign writeGo    = csRise & (st.phase == sei_pkg::SEI_DATA) & writeArmed & ~coreBusy;
   // the protect pin only counts while its enable bit is set
   assign protectNow = protectPinEnable & ~st.syncB.wpN;
   // next signature bit leaves on a falling clock while selected and running
   assign sigShift   = ~csN & ~csFall & ~csRise & ~st.paused & sckFall & (st.phase == sei_pkg::SEI_SIG);

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.syncA      = pinsIn;
      next_st.syncB      = st.syncA;
      next_st.sckPrev    = sck;
      next_st.csPrev     = csN;
      next_st.core.rxStrobe   = 1'b0;
      next_st.core.rxFirst    = 1'b0;
      next_st.core.frameEnd   = 1'b0;
      next_st.core.writeStart = 1'b0;

      // pause clears on deselect, otherwise changes only while the clock is low
      if (csN) begin
         next_st.paused = 1'b0;
      end else if (!sck) begin
         next_st.paused = ~st.syncB.holdN;
      end

      // deep power-down entry decoded by the core
      if (enterPowerDown) begin
         next_st.dpd = 1'b1;
      end

      // release delay countdown
      if (st.rel) begin
         if (relDone) begin
            next_st.rel = 1'b0;
         end else begin
            next_st.relCnt = st.relCnt - 1'b1;
         end
      end

      // standby after a running program cycle ends
      if (st.pendStandby && !coreBusy) begin
         next_st.pendStandby = 1'b0;
      end

      // frame start on a true high-to-low selection
      if (csFall) begin
         next_st.phase    = sei_pkg::SEI_OPCODE;
         next_st.bitCnt   = sei_pkg::BIT_CNT_RST;
         next_st.shiftIn  = sei_pkg::SHIFT_RST;
         next_st.wakeSeen = 1'b0;
         next_st.sigDone  = 1'b0;
         next_st.soDrive  = 1'b0;
      end else if (csRise) begin
         // deselect ends every frame
         next_st.phase   = sei_pkg::SEI_IDLE;
         next_st.soDrive = 1'b0;
         // only a frame that really ran reports its end
         if (st.phase != sei_pkg::SEI_IDLE) begin
            next_st.core.frameEnd = 1'b1;
         end
         // deselect after a wake opcode leaves deep power-down
         if (relLoad) begin
            next_st.dpd    = 1'b0;
            next_st.rel    = 1'b1;
            next_st.relCnt = sei_pkg::RELEASE_CNT_W'(sei_pkg::RELEASE_CYCLES - 1);
         end
         // a closed write frame starts the self-timed cycle
         if (writeGo) begin
            next_st.core.writeStart = 1'b1;
            // protect decision frozen as the cycle starts
            next_st.blocked = protectNow;
         end
         // standby waits for any program cycle
         if (coreBusy || writeArmed) begin
            next_st.pendStandby = 1'b1;
         end
      end else if (shiftOk) begin
         // one bit in, most significant first
         next_st.shiftIn = shifted;
         next_st.bitCnt  = st.bitCnt + 5'h01;
         unique case (st.phase)
            sei_pkg::SEI_OPCODE: begin
               if (opcodeLast) begin
                  next_st.bitCnt = sei_pkg::BIT_CNT_RST;
                  if (wakeHit) begin
                     next_st.phase    = sei_pkg::SEI_ADDR;
                     next_st.wakeSeen = 1'b1;
                  end else if (st.dpd) begin
                     next_st.phase = sei_pkg::SEI_IGNORE;
                  end else begin
                     next_st.phase          = sei_pkg::SEI_DATA;
                     next_st.core.rxByte    = shifted;
                     next_st.core.rxStrobe  = 1'b1;
                     next_st.core.rxFirst   = 1'b1;
                  end
               end
            end
            sei_pkg::SEI_ADDR: begin
               // dummy address is counted and discarded
               if (addrLast) begin
                  next_st.bitCnt = sei_pkg::BIT_CNT_RST;
                  next_st.phase  = sei_pkg::SEI_SIG;
                  next_st.sigIdx = sei_pkg::SIG_MSB;
               end
            end
            sei_pkg::SEI_DATA: begin
               // bytes after the opcode go to the core
               if (opcodeLast) begin
                  next_st.bitCnt        = sei_pkg::BIT_CNT_RST;
                  next_st.core.rxByte   = shifted;
                  next_st.core.rxStrobe = 1'b1;
               end
            end
            sei_pkg::SEI_SIG: begin
               next_st.bitCnt = sei_pkg::BIT_CNT_RST;
            end
            sei_pkg::SEI_IGNORE: begin
               next_st.bitCnt = sei_pkg::BIT_CNT_RST;
            end
            sei_pkg::SEI_IDLE: begin
               next_st.bitCnt = sei_pkg::BIT_CNT_RST;
            end
            default: begin
               next_st.phase  = sei_pkg::SEI_IDLE;
               next_st.bitCnt = sei_pkg::BIT_CNT_RST;
            end
         endcase
      end

      // signature shifted out on falling clock edges
      if (sigShift) begin
         next_st.soDrive = 1'b1;
         next_st.soBit   = SIGNATURE[st.sigIdx];
         next_st.sigIdx  = st.sigIdx - 3'h1;                    // wraps to repeat
         if (st.sigIdx == 3'h0) begin
            next_st.sigDone = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         // pins idle: deselected, not paused, unprotected
         st.syncA       <= '{csN: 1'b1, sck: 1'b0, si: 1'b0, holdN: 1'b1, wpN: 1'b1};
         st.syncB       <= '{csN: 1'b1, sck: 1'b0, si: 1'b0, holdN: 1'b1, wpN: 1'b1};
         st.sckPrev     <= 1'b0;
         st.csPrev      <= 1'b0;     // a low chip select at reset is still taken as a selection
         // sequencer idle
         st.paused      <= 1'b0;
         st.phase       <= sei_pkg::SEI_IDLE;
         st.bitCnt      <= sei_pkg::BIT_CNT_RST;
         st.shiftIn     <= sei_pkg::SHIFT_RST;
         st.sigIdx      <= sei_pkg::SIG_MSB;
         st.sigDone     <= 1'b0;
         st.wakeSeen    <= 1'b0;
         // output released
         st.soBit       <= 1'b0;
         st.soDrive     <= 1'b0;
         // core results and power state cleared
         st.core        <= '0;
         st.blocked     <= 1'b0;
         st.dpd         <= 1'b0;
         st.rel         <= 1'b0;
         st.relCnt      <= '0;
         st.pendStandby <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // output floats when deselected or paused, pause level taken directly
   assign soOut = st.soBit;
   assign soEnN = csN | ~st.syncB.holdN | ~st.soDrive;

   // core-facing results
   assign coreOut            = st.core;
   assign statusWriteBlocked = st.blocked;
   assign deepPowerDown      = st.dpd;
   assign releasing          = st.rel;
   // standby only once nothing is left running
   assign standby            = csN & ~st.rel & ~st.pendStandby & ~coreBusy;

endmodule

// ---- verif/sei_bus_interface_asserts.sv ----
`timescale 1ns/100ps
// ------------------------------
// port checks of the bus front end
// ------------------------------
module sei_bus_interface_asserts (
   input wire logic               clk_sys,
   input wire logic               rst_n,
   input wire sei_pkg::sei_pins_s pinsIn,
   input wire logic               enterPowerDown,
   input wire logic               coreBusy,
   input wire logic               protectPinEnable,
   input wire logic               soEnN,
   input wire sei_pkg::sei_core_s coreOut,
   input wire logic               statusWriteBlocked,
   input wire logic               deepPowerDown,
   input wire logic               releasing,
   input wire logic               standby
);
   localparam int RelCyc = sei_pkg::RELEASE_CYCLES;
   logic [8:0] relCnt;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // length of the current release window
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) relCnt <= 9'h000;
      else relCnt <= releasing ? relCnt + 9'h001 : 9'h000;
   end
   AST_DESELECT_FLOAT: assert property (pinsIn.csN [*3] |-> soEnN)
      else $error("output driven while deselected");
   AST_PAUSE_FLOAT: assert property (!pinsIn.holdN [*3] |-> soEnN)
      else $error("output driven while paused");
   AST_ENTER_PD: assert property (enterPowerDown && !releasing |=> deepPowerDown)
      else $error("power-down not entered");
   AST_RELEASE_LEN: assert property ($fell(releasing) |-> relCnt == 9'(RelCyc))
      else $error("release window length wrong");
   AST_RELEASE_BUSY: assert property (releasing |-> !standby && !deepPowerDown)
      else $error("standby during release");
   AST_BUSY_STANDBY: assert property (coreBusy [*2] |-> !standby)
      else $error("standby while busy");
   AST_WRITE_START: assert property (coreOut.writeStart |-> coreOut.frameEnd)
      else $error("write start without deselect");
   AST_PROTECT_OFF: assert property (coreOut.writeStart && !protectPinEnable |=> !statusWriteBlocked)
      else $error("blocked with enable clear");
   AST_PROTECT_ON: assert property (coreOut.writeStart && protectPinEnable && !pinsIn.wpN
      && !$past(pinsIn.wpN, 4) |=> statusWriteBlocked)
      else $error("not blocked with pin low");
   AST_FROZEN: assert property ($changed(statusWriteBlocked) |->
      coreOut.writeStart || $past(coreOut.writeStart))
      else $error("protect decision moved");
   AST_RX_PULSE: assert property (coreOut.rxStrobe |=> !coreOut.rxStrobe)
      else $error("byte strobe too long");
endmodule

bind sei_bus_interface sei_bus_interface_asserts u_asserts (.*);

// ---- verif/sei_host_model.sv ----
`timescale 1ns/100ps
// ------------------------------
// serial host driving the pins
// ------------------------------
module sei_host_model (
   input  wire logic         clk_sys,
   input  wire logic         soOut,
   input  wire logic         soEnN,
   output sei_pkg::sei_pins_s pins
);
   logic lastSo = 1'b0;
   logic soWire;
   // released line shows the inverse of the last bit
   always @(posedge clk_sys) if (!soEnN) lastSo <= soOut;
   assign soWire = soEnN ? ~lastSo : soOut;
   initial pins = '{csN: 1'b1, sck: 1'b0, si: 1'b0, holdN: 1'b1, wpN: 1'b1};
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // one bit: data while clock low, read before the rise
   task automatic xfer(input logic d, output logic q);
      pins.sck = 1'b0;
      pins.si = d;
      tick(4);
      q = soWire;
      pins.sck = 1'b1;
      tick(6);
   endtask
   task automatic byte8(input logic [7:0] d, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) xfer(d[i], q[i]);
   endtask
   task automatic sel(input logic cs);
      pins.sck = 1'b0;
      tick(4);
      pins.csN = cs;
      tick(6);
   endtask
   // pause with clock low, toggle clock while paused
   task automatic pause(output logic fl);
      pins.sck = 1'b0;
      tick(4);
      pins.holdN = 1'b0;
      tick(4);
      fl = soEnN;
      repeat (2) begin
         pins.sck = 1'b1;
         tick(4);
         pins.sck = 1'b0;
         tick(4);
      end
      pins.holdN = 1'b1;
      tick(4);
   endtask
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
   localparam logic [7:0] WAKE = 8'h3c;
   localparam logic [7:0] SIG  = 8'ha5; // arbitrary value
   logic clk_sys, rst_n, enterPowerDown, coreBusy, writeArmed, protectPinEnable, f;
   logic soOut, soEnN, statusWriteBlocked, deepPowerDown, releasing, standby;
   logic [7:0] lastByte, q, op;
   sei_pkg::sei_pins_s pins;
   sei_pkg::sei_core_s coreOut;
   int n_mismatch, tests_run, seed, nStart, nByte;
   sei_bus_interface #(.WAKE_OPCODE(WAKE), .SIGNATURE(SIG)) u_sei_bus_interface (
      .clk_sys(clk_sys), .rst_n(rst_n), .pinsIn(pins),
      .enterPowerDown(enterPowerDown), .coreBusy(coreBusy), .writeArmed(writeArmed),
      .protectPinEnable(protectPinEnable), .soOut(soOut), .soEnN(soEnN), .coreOut(coreOut),
      .statusWriteBlocked(statusWriteBlocked), .deepPowerDown(deepPowerDown),
      .releasing(releasing), .standby(standby));
   sei_host_model u_sei_host_model (.clk_sys(clk_sys), .soOut(soOut), .soEnN(soEnN), .pins(pins));
   // ------------------------------
   // compare and verdict
   // ------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic sendByte(input logic [7:0] d);
      lastByte = d;
      u_sei_host_model.byte8(d, q);
   endtask
   // given opcode, dummy address, two signature reads
   task automatic sigFrame(input logic [7:0] opc, input logic busy, input logic doPause);
      u_sei_host_model.sel(1'b0);
      sendByte(opc);
      repeat (2) sendByte(8'($random(seed)));
      for (int i = 0; i < 2; i++) begin
         sendByte(8'($random(seed)));
         if (!busy) check(q, SIG);
         if (doPause && i == 0) u_sei_host_model.pause(f);
         if (doPause && i == 0) check({7'h00, f}, 8'h01);
      end
      check({7'h00, soEnN}, {7'h00, busy});
      u_sei_host_model.sel(1'b1);
   endtask
   task automatic waitRelease();
      check({6'h00, deepPowerDown, releasing}, 8'h01);
      for (int i = 0; i < 300 && releasing !== 1'b0; i++) u_sei_host_model.tick(1);
      check({6'h00, releasing, standby}, 8'h01);
   endtask
   task automatic powerDown();
      enterPowerDown = 1'b1;
      u_sei_host_model.tick(1);
      enterPowerDown = 1'b0;
      u_sei_host_model.tick(1);
   endtask
   // byte strobes and write starts, looked at mid-cycle while they stand
   always @(negedge clk_sys) begin
      if (pins.csN === 1'b1) nByte = 0;
      if (coreOut.rxStrobe === 1'b1) begin
         check(coreOut.rxByte, lastByte);
         check({7'h00, coreOut.rxFirst}, {7'h00, nByte == 0});
         nByte++;
      end
      if (coreOut.writeStart === 1'b1) nStart++;
   end
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      #300000;
      n_mismatch++;
      print_verdict();
   end
   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      {rst_n, enterPowerDown, coreBusy, writeArmed, protectPinEnable} = 5'h00;
      seed = 86533;
      repeat (3) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      u_sei_host_model.tick(3);
      check({5'h00, standby, soEnN, deepPowerDown}, 8'h06);
      powerDown();
      op = 8'($random(seed));
      if (op === WAKE) op = ~op;
      sigFrame(op, 1'b1, 1'b0);
      check({7'h00, deepPowerDown}, 8'h01);
      sigFrame(WAKE, 1'b0, 1'b1);
      waitRelease();
      powerDown();
      u_sei_host_model.sel(1'b0);
      sendByte(WAKE);
      u_sei_host_model.sel(1'b1);
      waitRelease();
      for (int b = 0; b < 2; b++) begin
         coreBusy = b[0];
         sigFrame(WAKE, b[0], 1'b0);
      end
      coreBusy = 1'b0;
      writeArmed = 1'b1;
      for (int k = 0; k < 4; k++) begin
         protectPinEnable = k[1];
         u_sei_host_model.pins.wpN = k[0];
         nStart = 0;
         u_sei_host_model.sel(1'b0);
         sendByte(~WAKE);
         repeat (3) sendByte(8'($random(seed)));
         u_sei_host_model.sel(1'b1);
         check(nStart[7:0], 8'h01);
         check({7'h00, statusWriteBlocked}, {7'h00, k[1] & ~k[0]});
         u_sei_host_model.pins.wpN = 1'b0;
         u_sei_host_model.tick(6);
         check({7'h00, statusWriteBlocked}, {7'h00, k[1] & ~k[0]});
      end
      print_verdict();
   end
endmodule
